// [nvca_cyc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface nvca_cyc_if;
    import nvca_pkg::*;
    logic              start;
    logic [ADDR_W-1:0] addr;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport ctl (output start, output addr, input busy, input done, input rdata);
    modport eng (input start, input addr, output busy, output done, output rdata);
endinterface
`default_nettype wire

// [nvca_host.sv]
`timescale 1ns/1ps
`default_nettype none
module nvca_host
    import nvca_pkg::*;
#(
    parameter int unsigned POWERUP_WAIT = POWERUP_RESTORE_CNT,
    parameter int unsigned STORE_WAIT   = STORE_CNT
)(
    input  wire logic                      i_clk,
    input  wire logic                      i_rstn,
    input  wire logic                      i_req_read,
    input  wire logic                      i_req_seq,
    input  wire logic [ADDR_W-1:0]         i_addr,
    input  wire logic [SEQ_LEN*ADDR_W-1:0] i_seq_addr,
    input  wire logic                      i_seq_store,
    input  wire logic [DATA_W-1:0]         i_dq,
    output logic                           o_ready,
    output logic                           o_rvalid,
    output logic      [DATA_W-1:0]         o_rdata,
    output logic                           o_seq_done,
    output logic      [ADDR_W-1:0]         o_a,
    output logic                           o_ce_n,
    output logic                           o_oe_n,
    output logic                           o_we_n,
    output logic      [DATA_W-1:0]         o_dq,
    output logic                           o_dq_oe
);
    typedef enum logic [2:0] {
        H_POWERUP, H_IDLE, H_READ, H_SEQ, H_WAIT
    } nvca_state_type;

    logic             rst_s1;
    logic             rstn_q;
    nvca_state_type   state;
    nvca_state_type   next_state;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] next_wait_cnt;
    logic [2:0]       step;
    logic [2:0]       next_step;
    logic             store_q;
    logic             next_store_q;
    logic             next_rvalid;
    logic             next_seq_done;
    logic             next_oe_n;
    logic             prev_ce_n;
    logic [CNT_W-1:0] ce_gap;
    logic [CNT_W-1:0] next_ce_gap;
    logic [ADDR_W-1:0] seq_word [SEQ_LEN];

    nvca_cyc_if cyc ();

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_s1 <= 1'b0;
            rstn_q <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rstn_q <= rst_s1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < SEQ_LEN; g++) begin : g_seq
            assign seq_word[g] = i_seq_addr[g*ADDR_W +: ADDR_W];
        end
    endgenerate

    nvca_read_cycle u_cycle (
        .i_clk  (i_clk),
        .i_rstn (rstn_q),
        .cyc    (cyc.eng),
        .i_dq   (i_dq),
        .o_addr (o_a),
        .o_ce_n (o_ce_n)
    );

    always_comb begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        next_step     = step;
        next_store_q  = store_q;
        next_rvalid   = 1'b0;
        next_seq_done = 1'b0;
        next_oe_n     = o_oe_n;
        cyc.start     = 1'b0;
        cyc.addr      = i_addr;
        case (state)
            H_POWERUP: begin
                // Wait out the automatic restore after power-up.
                if (wait_cnt >= CNT_W'(POWERUP_WAIT - 1)) begin
                    next_state = H_IDLE;
                end else begin
                    next_wait_cnt = wait_cnt + 1'b1;
                end
            end
            H_IDLE: begin
                if (i_req_seq) begin
                    next_state   = H_SEQ;
                    next_step    = '0;
                    next_store_q = i_seq_store;
                    next_oe_n    = 1'b1;
                    cyc.start    = 1'b1;
                    cyc.addr     = seq_word[0];
                end else if (i_req_read) begin
                    next_state = H_READ;
                    next_oe_n  = 1'b0;
                    cyc.start  = 1'b1;
                end
            end
            H_READ: begin
                if (cyc.done) begin
                    next_state  = H_IDLE;
                    next_rvalid = 1'b1;
                    next_oe_n   = 1'b1;
                end
            end
            H_SEQ: begin
                // Six steps issued back to back with nothing between them.
                if (cyc.done) begin
                    if (step == 3'(SEQ_LEN - 1)) begin
                        next_state    = H_WAIT;
                        next_wait_cnt = '0;
                    end else begin
                        next_step = step + 1'b1;
                        cyc.start = 1'b1;
                        cyc.addr  = seq_word[step + 1'b1];
                    end
                end
            end
            default: begin
                // Hold off all accesses for the operation's maximum time.
                if (wait_cnt >= (store_q ? CNT_W'(STORE_WAIT - 1) : CNT_W'(RESTORE_CNT - 1))) begin
                    next_state    = H_IDLE;
                    next_seq_done = 1'b1;
                end else begin
                    next_wait_cnt = wait_cnt + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            state      <= H_POWERUP;
            wait_cnt   <= '0;
            step       <= '0;
            store_q    <= 1'b0;
            o_rvalid   <= 1'b0;
            o_seq_done <= 1'b0;
            o_oe_n     <= 1'b1;
        end else begin
            state      <= next_state;
            wait_cnt   <= next_wait_cnt;
            step       <= next_step;
            store_q    <= next_store_q;
            o_rvalid   <= next_rvalid;
            o_seq_done <= next_seq_done;
            o_oe_n     <= next_oe_n;
        end
    end

    // Cycles since chip select last fell; saturates once a full cycle time has passed.
    always_comb begin
        next_ce_gap = ce_gap;
        if (!o_ce_n && prev_ce_n) begin
            next_ce_gap = '0;
        end else if (ce_gap < CNT_W'(CYCLE_CNT)) begin
            next_ce_gap = ce_gap + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rstn_q) begin
        if (!rstn_q) begin
            prev_ce_n <= 1'b1;
            ce_gap    <= CNT_W'(CYCLE_CNT);
        end else begin
            prev_ce_n <= o_ce_n;
            ce_gap    <= next_ce_gap;
        end
    end

    assign o_rdata = cyc.rdata;
    // Only reads are issued, so the write strobe is never driven low.
    assign o_we_n  = 1'b1;
    assign o_dq    = '0;
    assign o_dq_oe = 1'b0;
    assign o_ready = (state == H_IDLE) && !cyc.busy;

    we_high_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        !o_ce_n |-> o_we_n && !o_dq_oe)
        else $error("write strobe low during a read");
    seq_we_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        state == H_SEQ |-> o_we_n)
        else $error("write strobe low inside a sequence");
    seq_gap_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        (state == H_SEQ && cyc.done && step != 3'(SEQ_LEN - 1)) |=> $fell(o_ce_n))
        else $error("gap between sequence steps");
    cycle_len_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        $fell(o_ce_n) |-> ce_gap >= CNT_W'(CYCLE_CNT - 1))
        else $error("sequence step shorter than cycle time");
    ce_oe_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        (state == H_SEQ) |-> o_oe_n)
        else $error("output gate active inside a sequence");
    powerup_hold_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        (state == H_POWERUP) |-> o_ce_n && !o_ready)
        else $error("access during power-up restore");
    hold_off_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        (state == H_WAIT) |-> o_ce_n && !o_ready)
        else $error("access during nonvolatile operation");
    seq_end_a: assert property (@(posedge i_clk) disable iff (!rstn_q)
        (state == H_SEQ && cyc.done && step == 3'(SEQ_LEN - 1)) |=> state == H_WAIT)
        else $error("sequence did not end after six steps");

    read_c: cover property (@(posedge i_clk) disable iff (!rstn_q) o_rvalid);
    seq_c: cover property (@(posedge i_clk) disable iff (!rstn_q) o_seq_done && store_q);
    recall_c: cover property (@(posedge i_clk) disable iff (!rstn_q) o_seq_done && !store_q);
    up_c: cover property (@(posedge i_clk) disable iff (!rstn_q) $rose(o_ready));
    step_c: cover property (@(posedge i_clk) disable iff (!rstn_q) state == H_SEQ && cyc.done);
endmodule // nvca_host
`default_nettype wire

// [nvca_host_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module nvca_host_test;
    import nvca_pkg::*;
    localparam int unsigned PW = 20;
    localparam int unsigned SW = 40;
    localparam int unsigned RW = 5000;
    logic                      i_clk;
    logic                      i_rstn;
    logic                      i_req_read;
    logic                      i_req_seq;
    logic                      i_seq_store;
    logic [ADDR_W-1:0]         i_addr;
    logic [SEQ_LEN*ADDR_W-1:0] i_seq_addr;
    logic [DATA_W-1:0]         dq;
    logic                      o_ready;
    logic                      o_rvalid;
    logic [DATA_W-1:0]         o_rdata;
    logic                      o_seq_done;
    logic [ADDR_W-1:0]         o_a;
    logic                      o_ce_n;
    logic                      o_oe_n;
    logic                      o_we_n;
    logic [DATA_W-1:0]         o_dq;
    logic                      o_dq_oe;
    int                        n_mismatch = 0;
    int                        check_count = 0;

    nvca_host #(.POWERUP_WAIT(PW), .STORE_WAIT(SW)) uut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_req_read(i_req_read), .i_req_seq(i_req_seq),
        .i_addr(i_addr), .i_seq_addr(i_seq_addr), .i_seq_store(i_seq_store), .i_dq(dq),
        .o_ready(o_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_seq_done(o_seq_done),
        .o_a(o_a), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_dq(o_dq),
        .o_dq_oe(o_dq_oe)
    );

    nvca_mem_model #(.MIN_CYC_NS(45.0), .RESTORE_NS(80.0)) mem (
        .i_a(o_a), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .o_dq(dq)
    );

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic complete_run;
        $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wait_ready;
        repeat (6000) begin
            @(negedge i_clk);
            if (o_ready === 1'b1) begin
                break;
            end
        end
        `CHK(o_ready, 1'b1)
    endtask

    task automatic check_reset;
        int n;
        n = 0;
        @(negedge i_clk);
        `CHK({o_ce_n, o_oe_n, o_we_n, o_ready, o_dq_oe, o_dq}, 13'h1C00)
        @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (200) begin
            @(posedge i_clk);
            #1;
            n++;
            if (o_ready === 1'b1) begin
                break;
            end
        end
        `CHK((n >= PW && n <= PW + 4), 1'b1)
    endtask

    task automatic do_read(input logic [ADDR_W-1:0] ad);
        int n;
        n = 0;
        wait_ready();
        @(posedge i_clk);
        i_addr     <= ad;
        i_req_read <= 1'b1;
        @(posedge i_clk);
        i_req_read <= 1'b0;
        repeat (40) begin
            @(posedge i_clk);
            #1;
            n++;
            `CHK(o_we_n, 1'b1)
            if (o_rvalid === 1'b1) begin
                break;
            end
        end
        `CHK(n, CYCLE_CNT + 1)
        `CHK(o_rdata, ad[7:0] ^ 8'h5A)
    endtask

    task automatic do_seq(input logic st, input int hold);
        int   n;
        int   f0;
        logic rv;
        n  = 0;
        rv = 1'b0;
        f0 = mem.n_fall;
        wait_ready();
        @(posedge i_clk);
        i_seq_store <= st;
        i_req_seq   <= 1'b1;
        @(posedge i_clk);
        i_req_seq <= 1'b0;
        repeat (hold + 200) begin
            @(posedge i_clk);
            if (n == 80) begin
                i_req_read <= 1'b1;
            end
            if (n == 90) begin
                i_req_read <= 1'b0;
            end
            #1;
            n++;
            rv = rv | (o_rvalid === 1'b1);
            if (o_seq_done === 1'b1) begin
                break;
            end
        end
        `CHK(n, SEQ_LEN * (CYCLE_CNT + 1) + hold)
        `CHK(rv, 1'b0)
        `CHK(mem.n_fall - f0, 6)
        for (int k = 0; k < 6; k++) begin
            `CHK(mem.log_a[(f0 + k) % 6], i_seq_addr[k*ADDR_W +: ADDR_W])
        end
        `CHK(mem.aborts, 0)
        `CHK(mem.we_bad, 0)
    endtask

    initial begin
        #80000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        i_rstn      = 1'b0;
        i_req_read  = 1'b0;
        i_req_seq   = 1'b0;
        i_seq_store = 1'b0;
        i_addr      = 13'h0000;
        for (int k = 0; k < 6; k++) begin
            i_seq_addr[k*ADDR_W +: ADDR_W] = 13'h0E38 + 13'(k) * 13'h0111;
        end
        repeat (3) @(posedge i_clk);
        check_reset();
        do_read(13'h0000);
        do_read(13'h1FFF);
        do_read(13'h0A5A);
        do_seq(1'b1, SW);
        do_seq(1'b0, RW);
        do_read(13'h0123);
        `CHK(mem.early, 0)
        complete_run();
    end
endmodule // nvca_host_test
`default_nettype wire

// [nvca_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module nvca_mem_model
    import nvca_pkg::*;
#(
    parameter realtime MIN_CYC_NS = 45.0,
    parameter realtime RESTORE_NS = 80.0
)(
    input  wire logic [ADDR_W-1:0] i_a,
    input  wire logic              i_ce_n,
    input  wire logic              i_oe_n,
    input  wire logic              i_we_n,
    output logic      [DATA_W-1:0] o_dq
);
    int          n_fall  = 0;
    int          we_bad  = 0;
    int          early   = 0;
    int          aborts  = 0;
    realtime     t_fall  = -1000.0;
    logic [ADDR_W-1:0] log_a [6];

    // Released bus shows the inverse pattern, so a stale sample never matches.
    always @* begin
        if (!i_ce_n && !i_oe_n && i_we_n && $realtime >= RESTORE_NS) begin
            o_dq = i_a[7:0] ^ 8'h5A;
        end else begin
            o_dq = ~(i_a[7:0] ^ 8'h5A);
        end
    end

    // Each falling chip-select edge registers one step; output gate is ignored.
    always @(negedge i_ce_n) begin
        if ($realtime < RESTORE_NS) begin
            early++;
        end
        if ($realtime - t_fall < MIN_CYC_NS) begin
            aborts++;
        end
        log_a[n_fall % 6] = i_a;
        n_fall++;
        t_fall = $realtime;
    end

    always @(negedge i_we_n) begin
        we_bad++;
    end
endmodule // nvca_mem_model
`default_nettype wire

// [nvca_pkg.sv]
// Operation
// - The host keeps the write strobe high through every read cycle.
// - The device takes each sequence step on the falling edge of chip select, ignoring output gate.
// - A copy or restore starts with six reads to the set addresses, back to back, in order.
// - The write strobe stays high through all six sequence cycles.
// - Each sequence cycle lasts at least the sequence cycle time of the speed grade.
package nvca_pkg;
    localparam int unsigned CLK_PERIOD_PS      = 4000;
    localparam int unsigned CYCLE_TIME_NS      = 45;
    localparam int unsigned CYCLE_CNT          = (CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                                 / CLK_PERIOD_PS;
    localparam int unsigned CE_LOW_TIME_NS     = 30;
    localparam int unsigned CE_LOW_CNT         = (CE_LOW_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                                 / CLK_PERIOD_PS;
    localparam int unsigned POWERUP_RESTORE_US = 550;
    localparam int unsigned POWERUP_RESTORE_CNT = POWERUP_RESTORE_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned STORE_TIME_US      = 10000;
    localparam int unsigned STORE_CNT          = STORE_TIME_US * (1000000 / CLK_PERIOD_PS);
    localparam int unsigned RESTORE_TIME_US    = 20;
    localparam int unsigned RESTORE_CNT        = RESTORE_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned ADDR_W             = 13;
    localparam int unsigned DATA_W             = 8;
    localparam int unsigned SEQ_LEN            = 6;
    localparam int unsigned CNT_W              = 32;
endpackage

// [nvca_read_cycle.sv]
`timescale 1ns/1ps
`default_nettype none
module nvca_read_cycle
    import nvca_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    nvca_cyc_if.eng                cyc,
    input  wire logic [DATA_W-1:0] i_dq,
    output logic      [ADDR_W-1:0] o_addr,
    output logic                   o_ce_n
);
    typedef enum logic {RC_IDLE, RC_RUN} nvca_rc_type;
    nvca_rc_type       state;
    nvca_rc_type       next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic [ADDR_W-1:0] next_addr;
    logic              next_ce_n;
    logic              next_done;
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_addr  = o_addr;
        next_ce_n  = 1'b1;
        next_done  = 1'b0;
        next_rdata = cyc.rdata;
        case (state)
            RC_IDLE: begin
                if (cyc.start) begin
                    next_state = RC_RUN;
                    next_addr  = cyc.addr;
                    next_cnt   = '0;
                    next_ce_n  = 1'b0;
                end
            end
            default: begin
                next_cnt  = cnt + 1'b1;
                // A single falling chip select edge per step, held low for the pulse width.
                next_ce_n = (cnt + 1'b1 >= CNT_W'(CE_LOW_CNT));
                if (cnt == CNT_W'(CE_LOW_CNT - 1)) begin
                    next_rdata = i_dq;
                end
                // The full cycle time elapses before the step ends.
                if (cnt == CNT_W'(CYCLE_CNT - 1)) begin
                    next_state = RC_IDLE;
                    next_done  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state     <= RC_IDLE;
            cnt       <= '0;
            o_addr    <= '0;
            o_ce_n    <= 1'b1;
            cyc.done  <= 1'b0;
            cyc.rdata <= '0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            o_addr    <= next_addr;
            o_ce_n    <= next_ce_n;
            cyc.done  <= next_done;
            cyc.rdata <= next_rdata;
        end
    end

    assign cyc.busy = (state == RC_RUN);

    ce_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $fell(o_ce_n) |-> !o_ce_n [*8] ##1 o_ce_n [*5])
        else $error("chip select pulse has the wrong shape");
endmodule // nvca_read_cycle
`default_nettype wire
